//--- hw/dual_iq_pkg.sv
package dual_iq_pkg;

	localparam int WORD_W            = 10;
	localparam int CELLS_W           = 32;
	localparam int SEG_CELLS         = 15;
	localparam int MAJOR_LSB         = 17;
	localparam int MINOR_LSB         = 2;
	localparam int LSB_LSB           = 0;
	localparam int LSB_BITS          = 2;
	localparam int FIR_TAPS          = 43;
	localparam int PATH_A_TAPS       = (FIR_TAPS + 1) / 2;
	localparam int HALF_A            = PATH_A_TAPS / 2;
	localparam int CENTER_DELAY      = (FIR_TAPS - 1) / 4 - 0;
	localparam int COEF_W            = 16;
	localparam int COEF_FRAC         = 14;
	localparam int ACC_W             = 32;
	localparam int SLEEP_HOLD_CYCLES = 4;

	localparam logic [WORD_W-1:0]     MID_CODE  = 10'h200;
	localparam logic [WORD_W-1:0]     SIGN_FLIP = 10'h200;
	localparam logic [CELLS_W-1:0]    CELLS_RST = 32'h0000_0000;
	localparam logic signed [ACC_W-1:0] ROUND_HALF = 32'sh0000_2000;
	localparam logic signed [ACC_W-1:0] SAT_HI     = 32'sh0000_01ff;
	localparam logic signed [ACC_W-1:0] SAT_LO     = -32'sh0000_0200;

	typedef logic signed [COEF_W-1:0] coef_t;
	typedef coef_t [0:HALF_A-1] coef_tab_t;

	// index 0 is the pair nearest the center; values are a plain default
	localparam coef_tab_t DEFAULT_COEFS = '{16'sh28d4, -16'sh0d70, 16'sh07ae, -16'sh051f,
		16'sh0385, -16'sh028f, 16'sh01cb, -16'sh0137, 16'sh00c5, -16'sh0073, 16'sh0031};
	localparam coef_t CENTER_COEF = 16'sh4000;

	typedef enum logic {WAIT_I, WAIT_Q} pair_state_t;

	function automatic logic [SEG_CELLS-1:0] therm(input logic [3:0] v);
		logic [SEG_CELLS-1:0] t;
		t = '0;
		for (int i = 0; i < SEG_CELLS; i++) begin
			t[i] = (int'(v) > i);
		end
		return t;
	endfunction

	function automatic logic [CELLS_W-1:0] cells_of(input logic [WORD_W-1:0] code);
		// major and minor fields thermometer coded, low bits passed straight through
		return {therm(code[9:6]), therm(code[5:2]), code[1:0]};
	endfunction

endpackage

//--- hw/flt_link_if.sv
`timescale 1ns/1ns
interface flt_link_if;
	logic                             load;
	logic                             sel;
	logic [dual_iq_pkg::WORD_W-1:0]   sample;
	logic [dual_iq_pkg::WORD_W-1:0]   code;

	modport src (output load, output sel, output sample, input code);
	modport flt (input load, input sel, input sample, output code);
endinterface

//--- hw/halfband_interp.sv
`timescale 1ns/1ns
module halfband_interp #(
	parameter dual_iq_pkg::coef_tab_t COEFS = dual_iq_pkg::DEFAULT_COEFS
) (
	input  wire logic clk,
	input  wire logic rst,
	flt_link_if.flt   lnk
);
	import dual_iq_pkg::*;

	typedef struct packed {
		logic [PATH_A_TAPS-1:0][WORD_W-1:0] hist;
		logic [WORD_W-1:0]                  code;
	} flt_state_t;

	flt_state_t        st_q;
	flt_state_t        st_d;
	logic [WORD_W-1:0] a_code;
	logic [WORD_W-1:0] b_code;

	// rounds, saturates and returns to straight binary
	function automatic logic [WORD_W-1:0] to_code(input logic signed [ACC_W-1:0] acc);
		logic signed [ACC_W-1:0] r;
		r = (acc + ROUND_HALF) >>> COEF_FRAC;
		if (r > SAT_HI) begin
			return 10'h3ff;
		end else if (r < SAT_LO) begin
			return 10'h000;
		end
		return r[WORD_W-1:0] ^ SIGN_FLIP;
	endfunction

	always_comb begin
		logic signed [ACC_W-1:0]  acc_a;
		logic signed [WORD_W:0]   pair;
		acc_a = '0;
		pair  = '0;
		// symmetric taps share one multiplier per pair
		for (int k = 0; k < HALF_A; k++) begin
			pair  = (WORD_W+1)'($signed(st_q.hist[k])) +
				(WORD_W+1)'($signed(st_q.hist[PATH_A_TAPS-1-k]));
			acc_a = acc_a + ACC_W'(pair) * ACC_W'(COEFS[HALF_A-1-k]);
		end
		a_code = to_code(acc_a);
		// odd half-band phase reduces to the center tap alone
		b_code = to_code(ACC_W'($signed(st_q.hist[CENTER_DELAY])) * ACC_W'(CENTER_COEF));
	end

	always_comb begin
		st_d = st_q;
		if (lnk.load) begin
			st_d.hist = {st_q.hist[PATH_A_TAPS-2:0], lnk.sample ^ SIGN_FLIP};
		end
		st_d.code = lnk.sel ? a_code : b_code;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '{hist: '0, code: MID_CODE};
		end else begin
			st_q <= st_d;
		end
	end

	assign lnk.code = st_q.code;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_path_even: assert property (lnk.sel |=> lnk.code == $past(a_code))
		else $error("even output not from summing path");
	a_path_odd: assert property (!lnk.sel |=> lnk.code == $past(b_code))
		else $error("odd output not from center path");
	a_filter_read: assert property (lnk.load |=>
		st_q.hist[0] == $past(lnk.sample ^ SIGN_FLIP))
		else $error("filter did not read its input register");
	a_hist_hold: assert property (!lnk.load |=> $stable(st_q.hist))
		else $error("filter history moved off the filter clock");
endmodule

//--- hw/dual_iq_interp_datapath.sv
`timescale 1ns/1ns
module dual_iq_interp_datapath (
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic [dual_iq_pkg::WORD_W-1:0]      input_word_bits,
	input  wire logic                                write_strobe,
	input  wire logic                                channel_select,
	output logic      [dual_iq_pkg::CELLS_W-1:0]     i_channel_true_output,
	output logic      [dual_iq_pkg::CELLS_W-1:0]     q_channel_true_output,
	output logic                                     power_down
);
	import dual_iq_pkg::*;

	typedef struct packed {
		logic                 wr;
		logic                 phase;
		pair_state_t          pst;
		logic [WORD_W-1:0]    i_hold;
		logic [WORD_W-1:0]    q_hold;
		logic [WORD_W-1:0]    i_pair;
		logic [WORD_W-1:0]    q_pair;
		logic [CELLS_W-1:0]   i_cells;
		logic [CELLS_W-1:0]   q_cells;
	} top_state_t;

	typedef struct packed {
		logic [SLEEP_HOLD_CYCLES-2:0] hist;
		logic                         pd;
	} sleep_state_t;

	top_state_t   st_q;
	top_state_t   st_d;
	sleep_state_t sl_q;
	sleep_state_t sl_d;
	logic         wr_rise;

	flt_link_if i_link ();
	flt_link_if q_link ();

	assign wr_rise = write_strobe & ~st_q.wr;

	always_comb begin
		st_d       = st_q;
		st_d.wr    = write_strobe;
		st_d.phase = ~st_q.phase;
		if (wr_rise) begin
			if (channel_select) begin
				st_d.i_hold = input_word_bits;
				// a second I before its Q restarts the pair
				st_d.pst    = WAIT_Q;
			end else begin
				st_d.q_hold = input_word_bits;
				if (st_q.pst == WAIT_Q) begin
					st_d.i_pair = st_q.i_hold;
					st_d.q_pair = input_word_bits;
					st_d.pst    = WAIT_I;
				end
			end
		end
		st_d.i_cells = cells_of(i_link.code);
		st_d.q_cells = cells_of(q_link.code);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// reset clears the input interface and the cell arrays; mid-scale holds keep the filters quiet
			st_q <= '{wr: 1'b0, phase: 1'b0, pst: WAIT_I, i_hold: MID_CODE,
				q_hold: MID_CODE, i_pair: MID_CODE, q_pair: MID_CODE,
				i_cells: CELLS_RST, q_cells: CELLS_RST};
		end else begin
			st_q <= st_d;
		end
	end

	// the hold detector must see reset itself, so it has no reset of its own
	always_comb begin
		sl_d      = sl_q;
		sl_d.hist = {sl_q.hist[SLEEP_HOLD_CYCLES-3:0], rst};
		sl_d.pd   = rst & (&sl_q.hist);
	end

	always_ff @(posedge clk) begin
		sl_q <= sl_d;
	end

	assign power_down = sl_q.pd;

	// one pair per two clocks matches the interleaved bus rate
	assign i_link.load   = ~st_q.phase;
	assign q_link.load   = ~st_q.phase;
	assign i_link.sel    = st_q.phase;
	assign q_link.sel    = st_q.phase;
	assign i_link.sample = st_q.i_pair;
	assign q_link.sample = st_q.q_pair;

	halfband_interp #(
		.COEFS (DEFAULT_COEFS)
	) u_i_filter (
		.clk (clk),
		.rst (rst),
		.lnk (i_link)
	);

	halfband_interp #(
		.COEFS (DEFAULT_COEFS)
	) u_q_filter (
		.clk (clk),
		.rst (rst),
		.lnk (q_link)
	);

	assign i_channel_true_output = st_q.i_cells;
	assign q_channel_true_output = st_q.q_cells;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_sync_update: assert property (1 |=>
		i_channel_true_output == cells_of($past(i_link.code)) &&
		q_channel_true_output == cells_of($past(q_link.code)))
		else $error("arrays did not update together from filters");
	a_filter_rate: assert property (i_link.load |=> !i_link.load ##1 i_link.load)
		else $error("filter clock is not half the input clock");
	a_pair_kept: assert property ((wr_rise && !channel_select && st_q.pst == WAIT_Q) |=>
		st_q.i_pair == $past(st_q.i_hold) && st_q.q_pair == $past(input_word_bits))
		else $error("I and Q pair broken");
	a_i_route: assert property ((wr_rise && channel_select) |=>
		st_q.i_hold == $past(input_word_bits) && $stable(st_q.q_hold))
		else $error("select high did not route to I");
	a_q_route: assert property ((wr_rise && !channel_select) |=>
		st_q.q_hold == $past(input_word_bits) && $stable(st_q.i_hold))
		else $error("select low did not route to Q");
	a_write_edge: assert property (!wr_rise |=> $stable(st_q.i_hold) && $stable(st_q.q_hold))
		else $error("input register changed without a strobe edge");
	a_sleep_long: assert property (@(posedge clk) disable iff (1'b0) rst [*4] |=> power_down)
		else $error("long reset did not power down");
	a_sleep_short: assert property (@(posedge clk) disable iff (1'b0)
		!rst ##1 rst [*3] ##1 !rst |-> !power_down)
		else $error("short reset caused power-down");
	a_major_therm: assert property (1 |=>
		$countones(i_channel_true_output[MAJOR_LSB +: SEG_CELLS]) == $past(i_link.code[9:6]) &&
		i_channel_true_output[MAJOR_LSB +: SEG_CELLS] ==
		therm($past(i_link.code[9:6])))
		else $error("major cells not thermometer coded");
	a_minor_therm: assert property (1 |=>
		$countones(q_channel_true_output[MINOR_LSB +: SEG_CELLS]) == $past(q_link.code[5:2]))
		else $error("minor cells count wrong");
	a_lsb_direct: assert property (1 |=>
		i_channel_true_output[LSB_LSB +: LSB_BITS] == $past(i_link.code[1:0]))
		else $error("low cells not driven directly");

	c_pair_done: cover property (wr_rise && channel_select ##[1:8] wr_rise && !channel_select);
	c_power_down: cover property (@(posedge clk) disable iff (1'b0) $rose(power_down));
	c_full_scale: cover property (i_link.code == 10'h3ff);
	c_double_i: cover property (wr_rise && channel_select ##[1:8] wr_rise && channel_select);
endmodule

//--- testbench/host_model.sv
`timescale 1ns/1ns
module host_model
	import dual_iq_pkg::*;
(
	input  wire logic                            clk,
	output logic      [dual_iq_pkg::WORD_W-1:0]  word,
	output logic                                 strobe,
	output logic                                 sel
);
	initial begin
		word = 10'h000;
		strobe = 1'b0;
		sel = 1'b0;
	end

	// one write, strobe high for one edge; then the bus is garbled, not left valid
	task automatic put(input logic [WORD_W-1:0] w, input logic s);
		@(posedge clk);
		word <= w;
		sel <= s;
		strobe <= 1'b1;
		@(posedge clk);
		strobe <= 1'b0;
		word <= ~w;
		sel <= ~s;
	endtask

	// i first, then q, so the device sees a complete pair
	task automatic put_pair(input logic [WORD_W-1:0] i, input logic [WORD_W-1:0] q);
		put(i, 1'b1);
		put(q, 1'b0);
	endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ns
module tb;
	import dual_iq_pkg::*;
	logic                clk;
	logic                rst;
	logic [WORD_W-1:0]   word;
	logic                strobe;
	logic                sel;
	logic                pdn;
	logic [CELLS_W-1:0]  i_cells;
	logic [CELLS_W-1:0]  q_cells;
	int                  bad_count = 0;
	int                  checks = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	dual_iq_interp_datapath dut (
		.clk                   (clk),
		.rst                   (rst),
		.input_word_bits       (word),
		.write_strobe          (strobe),
		.channel_select        (sel),
		.i_channel_true_output (i_cells),
		.q_channel_true_output (q_cells),
		.power_down            (pdn)
	);

	host_model host (
		.clk    (clk),
		.word   (word),
		.strobe (strobe),
		.sel    (sel)
	);

	function automatic logic [CELLS_W-1:0] enc(input logic [WORD_W-1:0] c);
		return {15'((16'h1 << c[9:6]) - 16'h1), 15'((16'h1 << c[5:2]) - 16'h1), c[1:0]};
	endfunction

	task automatic chk(input logic [CELLS_W-1:0] got, input logic [CELLS_W-1:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// a dc level settles through the filter; both phases and both channels compared
	task automatic t_dc(input logic [WORD_W-1:0] i, input logic [WORD_W-1:0] q);
		repeat (30) host.put_pair(i, q);
		repeat (4) begin
			@(negedge clk);
			chk(i_cells, enc(i));
			chk(q_cells, enc(q));
		end
	endtask

	// a second I replaces the pending one; a lone Q forms no pair
	task automatic t_refuse();
		repeat (30) begin
			host.put(10'h3ff, 1'b1);
			host.put(10'h100, 1'b1);
			host.put(10'h0c0, 1'b0);
			host.put(10'h3ff, 1'b0);
		end
		repeat (4) begin
			@(negedge clk);
			chk(i_cells, enc(10'h100));
			chk(q_cells, enc(10'h0c0));
		end
	endtask

	// reset pulse of n edges: only four or more means sleep
	task automatic t_pulse(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({31'h0, pdn}, (n >= 4) ? 32'h1 : 32'h0);
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk({31'h0, pdn}, 32'h0);
		chk(i_cells, enc(10'h200));
		chk(q_cells, enc(10'h200));
	endtask

	initial begin
		rst = 1'b1;
		repeat (19) @(posedge clk);
		@(negedge clk);
		chk({31'h0, pdn}, 32'h1);
		chk(i_cells, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, pdn}, 32'h0);
		chk(i_cells, enc(10'h200));
		t_dc(10'h3ff, 10'h000);
		t_pulse(3);
		t_dc(10'h000, 10'h3ff);
		t_dc(10'h155, 10'h2aa);
		t_refuse();
		t_pulse(4);
		t_dc(10'h0c7, 10'h381);
		summarize();
	end

	// everything above needs under 1500 cycles
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule
